// file: serial_port_pkg.sv
// constants, types and register map of the four-mode serial port
package serial_port_pkg;

    // register bus word and address
    typedef logic [1:0] addr_t;
    typedef logic [7:0] byte_t;

    // register indices
    localparam addr_t ADDR_CTRL = 2'h0;
    localparam addr_t ADDR_BUF = 2'h1;
    localparam addr_t ADDR_CFG = 2'h2;

    // control register layout, msb first
    typedef struct packed {
        logic modeSelectHigh;
        logic modeSelectLow;
        logic multiprocessorQualify;
        logic receiveEnable;
        logic transmitNinthBit;
        logic receivedNinthBit;
        logic transmitFlag;
        logic receiveFlag;
    } ctrl_s;

    // configuration register layout
    typedef struct packed {
        logic [5:0] reserved;
        logic doubleRate;
        logic sixClock;
    } cfg_s;

    // values after reset
    localparam byte_t CTRL_RESET = 8'h00;
    localparam byte_t CFG_RESET = 8'h00;
    localparam byte_t BUF_RESET = 8'h00;
    localparam logic [8:0] TX_SHIFT_RESET = 9'h000;
    localparam logic [8:0] RX_SHIFT_RESET = 9'h1FF;

    // configuration bit positions
    localparam int CFG_SIX_BIT = 0;
    localparam int CFG_DOUBLE_BIT = 1;

    // machine cycle states S1..S6
    localparam logic [2:0] ST_S1 = 3'h0;
    localparam logic [2:0] ST_S3 = 3'h2;
    localparam logic [2:0] ST_S5 = 3'h4;
    localparam logic [2:0] ST_S6 = 3'h5;

    // bit time counter states
    localparam logic [3:0] DIV_LAST = 4'hF;
    localparam logic [3:0] SAMPLE_FIRST = 4'h6;
    localparam logic [3:0] SAMPLE_LAST = 4'h8;

    // fixed-rate prescaler top count
    localparam logic [1:0] PRESC_MAX = 2'h3;

    // receive shift register preload values
    localparam logic [8:0] SYNC_RX_LOAD = 9'h1FE;
    localparam logic [8:0] ASYNC_RX_LOAD = 9'h1FF;

    // transmit control states
    typedef enum logic [5:0] {
        TX_IDLE = 6'h01,
        TX_PEND = 6'h02,
        TX_ARM = 6'h04,
        TX_START = 6'h08,
        TX_DATA = 6'h10,
        TX_LAST = 6'h20
    } tx_state_e;

    // receive control states
    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_ARM = 6'h02,
        RX_SHIFT = 6'h04,
        RX_END = 6'h08,
        RX_BITS = 6'h10,
        RX_TAIL = 6'h20
    } rx_state_e;

endpackage : serial_port_pkg

// file: rx_bit_detector.sv
// input synchroniser and three-sample majority bit detector
`timescale 1ns/1ps
module rx_bit_detector (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pinIn,
    input wire logic sampleEn,
    output logic level,
    output logic vote
);
    logic meta;
    logic [2:0] samples;

    // two flops before any logic looks at the pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            meta <= 1'b1;
            level <= 1'b1;
        end else begin
            meta <= pinIn;
            level <= meta;
        end
    end

    // keep the last three samples of the bit
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            samples <= 3'h7;
        end else if (sampleEn) begin
            samples <= {samples[1:0], level};
        end
    end

    // two of three wins
    assign vote = (samples[0] & samples[1]) | (samples[0] & samples[2])
        | (samples[1] & samples[2]);

endmodule : rx_bit_detector

// file: serial_port_four_mode.sv
// four-mode serial port: shift register mode and three uart modes
//
// Contract
// [RULE1] sync mode: data both ways on pin zero, clock on pin one, 8 bits
// [RULE2] sync buffer write loads marker 1, send starts one cycle later
// [RULE3] sync shift clock low S3-S5, high S6-S2; shift right at S6P2
// [RULE4] zeros in from left; final shift, flag set at S1P1 cycle ten
// [RULE5] sync receive starts on enable and clear flag; preload 11111110
// [RULE6] sync receive samples pin at S5P2, shifts left at S6P2
// [RULE7] sync receive: final shift loads buffer, flag at S1P1 cycle ten
// [RULE8] mode 1 frame: start 0, 8 data lsb first, stop 1 to ninth flag
// [RULE9] async write loads ninth bit; send waits for next rollover
// [RULE10] async send: start bit, then data one bit time later, then shift
// [RULE11] mode 1 send ends, flag set, at tenth rollover after write
// [RULE12] modes 2/3: first shift inserts stop 1; ends at eleventh rollover
// [RULE13] async receive starts on falling edge; reset counter, preload 1FF
// [RULE14] each bit sampled at states 7, 8, 9; majority accepted
// [RULE15] start bit not 0: abandon and hunt for a new falling edge
// [RULE16] mode 1 frame kept only if flag clear and qualify off or stop 1
// [RULE17] mode 1 returns to hunting after frame, kept or not
// [RULE18] modes 2/3 frame: start, 8 data, ninth bit, stop
// [RULE19] mode 2 fixed rate from oscillator; modes 1/3 from timer overflow
// [RULE20] modes 2/3 keep frame if flag clear and qualify off or ninth 1
// [RULE21] ninth bit flag holds received ninth bit, unused in sync mode
// [RULE22] external register keeps data stable around sampling point
`timescale 1ns/1ps
module serial_port_four_mode (
    input wire logic clk_sys,
    input wire logic srst,
    input serial_port_pkg::addr_t regAddr,
    input serial_port_pkg::byte_t regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output serial_port_pkg::byte_t regRdata,
    input wire logic timerOverflow,
    input wire logic portThreeBitZeroIn,
    output logic portThreeBitZeroOut,
    output logic portThreeBitZeroOeN,
    output logic portThreeBitOneOut
);
    import serial_port_pkg::*;

    ctrl_s serialControlReg;
    cfg_s serialConfigReg;
    byte_t serialBuffer;
    tx_state_e txState;
    rx_state_e rxState;
    logic [8:0] txShift, rxShift;
    logic [2:0] stateNum;
    logic [1:0] presc, prescLimit, rateShift;
    logic [3:0] txDiv, rxDiv;
    logic phaseTwo, ovfHalf, rxPrev, syncSample, txFirst, pinLevel, pinVote;
    logic syncMode, modeOne, modeTwo, sixClk, p1, p2, atS1P1, atS5P2, atS6P2;
    logic tick, txRoll, rxRoll, sampleEn, wrCtrl, wrBuf, wrCfg, ninthLoad;
    logic shiftNow, shiftIn, txFinal, txSet, startDetect, startBad;
    logic asyncFinal, rxAccept, syncLoad, rxSet, syncActive;
    // register strobes
    assign wrCtrl = regWr & (regAddr == ADDR_CTRL);
    assign wrBuf = regWr & (regAddr == ADDR_BUF);
    assign wrCfg = regWr & (regAddr == ADDR_CFG);
    // mode decode
    assign syncMode = ~serialControlReg.modeSelectHigh
        & ~serialControlReg.modeSelectLow;
    assign modeOne = ~serialControlReg.modeSelectHigh
        & serialControlReg.modeSelectLow;
    assign modeTwo = serialControlReg.modeSelectHigh
        & ~serialControlReg.modeSelectLow;
    assign sixClk = serialConfigReg.sixClock;
    // machine cycle phase strobes; six-clock mode packs P1 and P2 together
    assign p1 = sixClk | ~phaseTwo;
    assign p2 = sixClk | phaseTwo;
    assign atS1P1 = (stateNum == ST_S1) & p1;
    assign atS5P2 = (stateNum == ST_S5) & p2;
    assign atS6P2 = (stateNum == ST_S6) & p2;
    // state and phase counter driven by the oscillator
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stateNum <= ST_S1;
            phaseTwo <= 1'b0;
        end else begin
            phaseTwo <= ~sixClk & ~phaseTwo; // [RULE1]
            if (p2) begin
                stateNum <= (stateNum == ST_S6) ? ST_S1 : stateNum + 3'h1;
            end
        end
    end
    // sixteen-times bit rate tick: fixed for mode 2, timer for modes 1/3
    assign rateShift = {1'b0, serialConfigReg.doubleRate} + {1'b0, sixClk};
    assign prescLimit = PRESC_MAX >> rateShift;
    assign tick = modeTwo ? (presc == prescLimit)
        : (timerOverflow & (serialConfigReg.doubleRate | ovfHalf)); // [RULE19]
    // prescaler and timer overflow halver
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            presc <= 2'h0;
            ovfHalf <= 1'b0;
        end else begin
            presc <= (modeTwo & (presc != prescLimit)) ? presc + 2'h1 : 2'h0;
            if (timerOverflow) begin
                ovfHalf <= ~ovfHalf;
            end
        end
    end
    // free-running transmit bit time counter
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txDiv <= 4'h0;
        end else if (tick) begin
            txDiv <= txDiv + 4'h1;
        end
    end
    assign txRoll = tick & (txDiv == DIV_LAST);
    // transmit shift control
    assign ninthLoad = modeOne | syncMode | serialControlReg.transmitNinthBit;
    assign shiftNow = syncMode ? atS6P2 : txRoll;
    assign shiftIn = txFirst & ~modeOne & ~syncMode; // [RULE12]
    assign txFinal = ~txFirst & (txShift[8:2] == 7'h00) & txShift[1];
    assign txSet = (txState == TX_LAST & atS1P1)
        | (txState == TX_DATA & shiftNow & txFinal & ~syncMode);

    // transmit state machine
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            txState <= TX_IDLE;
            txShift <= TX_SHIFT_RESET;
            txFirst <= 1'b0;
        end else begin
            case (txState)
                TX_IDLE: begin
                    if (wrBuf) begin
                        txShift <= {ninthLoad, regWdata}; // [RULE2] [RULE9]
                        txState <= TX_PEND;
                    end
                end
                TX_PEND: begin
                    if (syncMode & atS1P1) begin
                        txState <= TX_ARM;
                    end else if (~syncMode & txRoll) begin
                        txState <= TX_START; // [RULE9]
                    end
                end
                TX_ARM: begin
                    if (atS1P1) begin
                        txState <= TX_DATA; // [RULE2]
                    end
                end
                TX_START: begin
                    if (txRoll) begin
                        txState <= TX_DATA; // [RULE10]
                        txFirst <= 1'b1;
                    end
                end
                TX_DATA: begin
                    if (shiftNow) begin
                        txShift <= {shiftIn, txShift[8:1]}; // [RULE3] [RULE4]
                        txFirst <= 1'b0;
                        if (txFinal) begin
                            // [RULE11] [RULE12]
                            txState <= syncMode ? TX_LAST : TX_IDLE;
                        end
                    end
                end
                TX_LAST: begin
                    if (atS1P1) begin
                        txState <= TX_IDLE; // [RULE4]
                    end
                end
                default: txState <= TX_IDLE;
            endcase
        end
    end

    // pin zero synchroniser and majority detector
    rx_bit_detector detector (
        .clk_sys(clk_sys),
        .srst(srst),
        .pinIn(portThreeBitZeroIn),
        .sampleEn(sampleEn),
        .level(pinLevel),
        .vote(pinVote)
    );

    // receive bit time counter, realigned on each start edge
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxDiv <= 4'h0;
            rxPrev <= 1'b1;
        end else begin
            if (tick) begin
                rxPrev <= pinLevel;
            end
            if (startDetect) begin
                rxDiv <= 4'h0; // [RULE13]
            end else if (tick) begin
                rxDiv <= rxDiv + 4'h1;
            end
        end
    end

    // start edge, sampling window and bit boundaries
    assign startDetect = tick & rxPrev & ~pinLevel & ~syncMode
        & serialControlReg.receiveEnable & (rxState == RX_IDLE); // [RULE13]
    assign sampleEn = tick & (rxState == RX_BITS)
        & (rxDiv >= SAMPLE_FIRST) & (rxDiv <= SAMPLE_LAST); // [RULE14]
    assign rxRoll = tick & (rxDiv == DIV_LAST);
    assign startBad = (rxShift == ASYNC_RX_LOAD) & pinVote; // [RULE15]
    assign asyncFinal = (rxState == RX_BITS) & rxRoll & ~startBad
        & ~rxShift[8];
    assign rxAccept = asyncFinal & ~serialControlReg.receiveFlag
        & (~serialControlReg.multiprocessorQualify | pinVote); // [RULE16] [RULE20]
    assign syncLoad = (rxState == RX_SHIFT) & atS6P2 & ~rxShift[7];
    assign rxSet = rxAccept | ((rxState == RX_END) & atS1P1); // [RULE7]

    // sync receive sample of the pin
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            syncSample <= 1'b1;
        end else if (atS5P2) begin
            syncSample <= pinLevel; // [RULE6]
        end
    end

    // receive state machine
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rxState <= RX_IDLE;
            rxShift <= RX_SHIFT_RESET;
        end else begin
            case (rxState)
                RX_IDLE: begin
                    if (syncMode & atS1P1 & serialControlReg.receiveEnable
                        & ~serialControlReg.receiveFlag) begin
                        rxState <= RX_ARM; // [RULE5]
                    end else if (startDetect) begin
                        rxShift <= ASYNC_RX_LOAD; // [RULE13]
                        rxState <= RX_BITS;
                    end
                end
                RX_ARM: begin
                    if (atS6P2) begin
                        rxShift <= SYNC_RX_LOAD; // [RULE5]
                        rxState <= RX_SHIFT;
                    end
                end
                RX_SHIFT: begin
                    if (atS6P2) begin
                        rxShift <= {rxShift[7:0], syncSample}; // [RULE6]
                        if (~rxShift[7]) begin
                            rxState <= RX_END; // [RULE7]
                        end
                    end
                end
                RX_END: begin
                    if (atS1P1) begin
                        rxState <= RX_IDLE;
                    end
                end
                RX_BITS: begin
                    if (rxRoll) begin
                        if (startBad) begin
                            rxState <= RX_IDLE; // [RULE15]
                        end else begin
                            rxShift <= {rxShift[7:0], pinVote}; // [RULE14]
                            if (~rxShift[8]) begin
                                // [RULE17] [RULE20]
                                rxState <= modeOne ? RX_IDLE : RX_TAIL;
                            end
                        end
                    end
                end
                RX_TAIL: begin
                    if (rxRoll) begin
                        rxState <= RX_IDLE; // [RULE20]
                    end
                end
                default: rxState <= RX_IDLE;
            endcase
        end
    end

    // receive buffer, data put back in lsb-first order
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            serialBuffer <= BUF_RESET;
        end else if (rxAccept) begin
            serialBuffer <= {<<{rxShift[7:0]}}; // [RULE8] [RULE18]
        end else if (syncLoad) begin
            serialBuffer <= {<<{rxShift[6:0], syncSample}}; // [RULE1] [RULE7]
        end
    end

    // control register; hardware sets win over a software write
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            serialControlReg <= ctrl_s'(CTRL_RESET);
        end else begin
            if (wrCtrl) begin
                serialControlReg <= ctrl_s'(regWdata);
            end
            if (txSet) begin
                serialControlReg.transmitFlag <= 1'b1; // [RULE4] [RULE11]
            end
            if (rxSet) begin
                serialControlReg.receiveFlag <= 1'b1;
            end
            if (rxAccept) begin
                // stop bit in mode 1, ninth bit in modes 2/3
                serialControlReg.receivedNinthBit <= pinVote; // [RULE8] [RULE21]
            end
        end
    end

    // configuration register: clock mode and double rate
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            serialConfigReg <= cfg_s'(CFG_RESET);
        end else if (wrCfg) begin
            serialConfigReg.sixClock <= regWdata[CFG_SIX_BIT];
            serialConfigReg.doubleRate <= regWdata[CFG_DOUBLE_BIT];
        end
    end

    // registered read data, valid only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            case (regAddr)
                ADDR_CTRL: regRdata <= serialControlReg;
                ADDR_BUF: regRdata <= serialBuffer;
                ADDR_CFG: regRdata <= serialConfigReg;
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // sync mode: shift clock runs while sending or receiving
    assign syncActive = (txState == TX_DATA) | (txState == TX_LAST)
        | (rxState == RX_SHIFT) | (rxState == RX_END);

    // pin drivers
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            portThreeBitOneOut <= 1'b1;
            portThreeBitZeroOut <= 1'b1;
            portThreeBitZeroOeN <= 1'b1;
        end else if (syncMode) begin
            // [RULE3] [RULE6]
            portThreeBitOneOut <= ~(syncActive & (stateNum >= ST_S3)
                & (stateNum <= ST_S5));
            portThreeBitZeroOut <= txShift[0]; // [RULE1]
            portThreeBitZeroOeN <= ~((txState == TX_DATA)
                | (txState == TX_LAST));
        end else begin
            case (txState)
                TX_START: portThreeBitOneOut <= 1'b0; // [RULE10]
                TX_DATA: portThreeBitOneOut <= txShift[0]; // [RULE8] [RULE18]
                default: portThreeBitOneOut <= 1'b1;
            endcase
            portThreeBitZeroOut <= 1'b1;
            portThreeBitZeroOeN <= 1'b1;
        end
    end

endmodule : serial_port_four_mode

// file: serial_port_four_mode_asserts.sv
// port-level assertions for the four-mode serial port
`timescale 1ns/1ps
module serial_port_four_mode_asserts (
    input wire logic clk_sys,
    input wire logic srst,
    input serial_port_pkg::addr_t regAddr,
    input serial_port_pkg::byte_t regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input serial_port_pkg::byte_t regRdata,
    input wire logic portThreeBitZeroOeN,
    input wire logic portThreeBitOneOut
);
    import serial_port_pkg::*;
    byte_t ctrl;
    byte_t cfg;
    logic [7:0] lowCnt;
    logic [3:0] riseCnt;
    logic [9:0] lineLow;
    logic [9:0] bitMask;
    logic slowSync;
    assign slowSync = ctrl[7:6] == 2'h0 && !cfg[0];
    assign bitMask = (cfg[1] && cfg[0]) ? 10'h00F :
        ((cfg[1] || cfg[0]) ? 10'h01F : 10'h03F);
    // shadow of software writes
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl <= CTRL_RESET;
            cfg <= CFG_RESET;
        end else if (regWr && regAddr == ADDR_CTRL) begin
            ctrl <= regWdata;
        end else if (regWr && regAddr == ADDR_CFG) begin
            cfg <= regWdata;
        end
    end
    // run lengths and shift clock edges while sending
    always_ff @(posedge clk_sys) begin
        if (srst || portThreeBitZeroOeN) begin
            lowCnt <= 8'h00;
            riseCnt <= 4'h0;
        end else begin
            lowCnt <= lowCnt + 8'h01;
            riseCnt <= riseCnt + 4'($rose(portThreeBitOneOut));
        end
        if (srst || portThreeBitOneOut) lineLow <= 10'h000;
        else lineLow <= lineLow + 10'h001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence clkLow;
        !portThreeBitOneOut [*6] ##1 portThreeBitOneOut;
    endsequence
    sequence clkHigh;
        portThreeBitOneOut [*6];
    endsequence
    a_read_idle_zero: assert property (!$past(regRd) |-> regRdata == 8'h00)
        else $error("read data not zero");
    a_clock_low_phase: assert property (
        $fell(portThreeBitOneOut) && slowSync |-> clkLow)
        else $error("clock low wrong");
    a_clock_high_phase: assert property (
        $rose(portThreeBitOneOut) && slowSync |-> clkHigh)
        else $error("clock high wrong");
    a_send_start: assert property (regWr && regAddr == ADDR_BUF &&
        slowSync && portThreeBitZeroOeN |-> ##[12:26] !portThreeBitZeroOeN)
        else $error("no sync send");
    a_send_length: assert property (
        $rose(portThreeBitZeroOeN) && slowSync |-> lowCnt == 8'h60)
        else $error("send length");
    a_shift_count: assert property (
        $rose(portThreeBitZeroOeN) |-> riseCnt == 4'h8)
        else $error("clock count");
    a_async_start: assert property (regWr && regAddr == ADDR_BUF &&
        ctrl[7:6] == 2'h2 |-> ##[1:66] !portThreeBitOneOut)
        else $error("no start bit");
    a_bit_multiple: assert property (
        $rose(portThreeBitOneOut) && ctrl[7:6] == 2'h2 |->
        (lineLow & bitMask) == 10'h000 && lineLow != 10'h000)
        else $error("bit time");
endmodule : serial_port_four_mode_asserts

// file: serial_peer.sv
// far end: uart peer and external shift register
`timescale 1ns/1ps
module serial_peer #(
    parameter int BIT_CLK = 32
) (
    input wire logic clk_sys,
    input wire logic asyncOn,
    input wire logic pinOne,
    input wire logic pinZeroOut,
    input wire logic pinZeroOeN,
    output logic pinZeroIn,
    output logic gotValid,
    output logic [8:0] gotWord
);
    logic drv = 1'b1;
    logic prevOne = 1'b1;
    logic [7:0] syncSh = 8'h00;
    logic [3:0] syncLeft = 4'h0;
    logic [3:0] capCnt = 4'h0;
    logic [8:0] capSh = 9'h000;
    int aCnt = 0;
    // wire level: device drives when its enable is low, else peer
    assign pinZeroIn = pinZeroOeN ? drv : pinZeroOut;
    // shift register on rising shift clock, uart capture mid-bit
    always @(posedge clk_sys) begin
        prevOne <= pinOne;
        gotValid <= 1'b0;
        if (!asyncOn && pinOne && !prevOne && !pinZeroOeN) begin
            capSh <= {1'b0, pinZeroOut, capSh[7:1]};
            capCnt <= capCnt == 4'h7 ? 4'h0 : capCnt + 4'h1;
            gotValid <= capCnt == 4'h7;
            gotWord <= {1'b0, pinZeroOut, capSh[7:1]};
        end
        if (!asyncOn && pinOne && !prevOne && pinZeroOeN && syncLeft != 0) begin
            syncSh <= syncSh >> 1;
            drv <= syncLeft == 4'h1 ? 1'b1 : syncSh[1];
            syncLeft <= syncLeft - 4'h1;
        end
        if (asyncOn && aCnt == 0 && !pinOne && prevOne) aCnt <= 1;
        if (asyncOn && aCnt != 0) begin
            aCnt <= aCnt + 1;
            if (aCnt % BIT_CLK == BIT_CLK / 2 && aCnt > BIT_CLK) begin
                capSh <= {pinOne, capSh[8:1]};
            end
            if (aCnt == BIT_CLK * 9 + BIT_CLK / 2) begin
                gotValid <= 1'b1;
                gotWord <= {pinOne, capSh[8:1]};
                aCnt <= 0;
            end
        end
    end
    // data for a sync reception, bit zero shown first
    task automatic loadSync(input logic [7:0] v);
        syncSh <= v;
        drv <= v[0];
        syncLeft <= 4'h8;
    endtask : loadSync
    // uart frame lsb first, optional short false start before it
    task automatic sendFrame(input logic [10:0] bits, input logic glitch);
        if (glitch) begin
            drv <= 1'b0;
            repeat (4) @(posedge clk_sys);
            drv <= 1'b1;
            repeat (2 * BIT_CLK) @(posedge clk_sys);
        end
        for (int i = 0; i < 11; i++) begin
            drv <= bits[i];
            repeat (BIT_CLK) @(posedge clk_sys);
        end
    endtask : sendFrame
endmodule : serial_peer

// file: tb_top.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/1ps
module tb_top;
    import serial_port_pkg::*;
    logic clk_sys, srst, regWr, regRd, timerOverflow, pinZeroIn, pinZeroOut;
    logic pinZeroOeN, pinOne, asyncOn, gotValid, rdPend, rdChk, chkNext, acc;
    addr_t regAddr;
    byte_t regWdata, regRdata, d, lastRd, lastBuf, rdQ[$];
    logic [8:0] gotWord, wordQ[$];
    logic [4:0] rc;
    int n_mismatch, cmp_count, cycles;
    serial_port_four_mode DUT (.clk_sys, .srst, .regAddr, .regWdata, .regWr,
        .regRd, .regRdata, .timerOverflow, .portThreeBitZeroIn(pinZeroIn),
        .portThreeBitZeroOut(pinZeroOut), .portThreeBitZeroOeN(pinZeroOeN),
        .portThreeBitOneOut(pinOne));
    serial_peer #(.BIT_CLK(32)) peer (.clk_sys, .asyncOn, .pinOne,
        .pinZeroOut, .pinZeroOeN, .pinZeroIn, .gotValid, .gotWord);
    // clock and timer overflow every second cycle
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) timerOverflow <= !timerOverflow && !srst;
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task automatic cmpByte(input byte_t got, input byte_t exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpByte
    task automatic cmpWord(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpWord
    task automatic wr(input addr_t a, input byte_t v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clk_sys);
        regWr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input addr_t a, input logic chk, input byte_t exp);
        regAddr <= a;
        regRd <= 1'b1;
        chkNext <= chk;
        if (chk) rdQ.push_back(exp);
        @(posedge clk_sys);
        regRd <= 1'b0;
        @(negedge clk_sys);
        lastRd = regRdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic waitBit(input int b);
        lastRd = 8'h00;
        for (int i = 0; i < 400 && !lastRd[b]; i++) rd(ADDR_CTRL, 1'b0, 8'h00);
        if (!lastRd[b]) n_mismatch++;
    endtask : waitBit
    // watcher: each result against the oldest note
    always @(posedge clk_sys) begin
        rdPend <= regRd;
        rdChk <= chkNext;
        if (rdPend && rdChk) cmpByte(regRdata, rdQ.pop_front());
        if (gotValid) cmpWord(gotWord, wordQ.pop_front());
        cycles++;
        if (cycles > 30000) begin
            n_mismatch++;
            final_report();
        end
    end
    initial begin
        {regAddr, regWdata, regWr, regRd, chkNext, rdPend, rdChk} = '0;
        {timerOverflow, asyncOn, n_mismatch, cmp_count, cycles} = '0;
        srst = 1'b1;
        d = $urandom(33);
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd(ADDR_CTRL, 1'b1, CTRL_RESET);
        rd(ADDR_BUF, 1'b1, BUF_RESET);
        rd(2'h3, 1'b1, 8'h00);
        d = $urandom;
        wr(ADDR_CFG, d);
        wr(2'h3, ~d);
        rd(ADDR_CFG, 1'b1, d & 8'h03);
        d = $urandom;
        d = {2'h1, d[5], 1'b0, d[3:0]};
        wr(ADDR_CTRL, d);
        rd(ADDR_CTRL, 1'b1, d);
        $display("registers test done");
        wr(ADDR_CFG, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        d = $urandom;
        wordQ.push_back({1'b0, d});
        wr(ADDR_BUF, d);
        waitBit(1);
        rd(ADDR_CTRL, 1'b1, 8'h02);
        d = $urandom;
        peer.loadSync(d);
        wr(ADDR_CTRL, 8'h10);
        waitBit(0);
        rd(ADDR_CTRL, 1'b1, 8'h11);
        rd(ADDR_BUF, 1'b1, d);
        lastBuf = d;
        $display("sync mode test done");
        wr(ADDR_CFG, 8'h02);
        asyncOn <= 1'b1;
        for (int m = 1; m < 4; m++) begin
            d = $urandom;
            acc = 1'($urandom);
            wr(ADDR_CTRL, {2'(m), 3'h0, acc, 2'h0});
            wordQ.push_back({m == 1 ? 1'b1 : acc, d});
            wr(ADDR_BUF, d);
            waitBit(1);
        end
        $display("async transmit test done");
        // cases: mode, qualify, ninth bit, flag already set
        for (int i = 0; i < 5; i++) begin
            rc = i == 0 ? 5'b01110 : i == 1 ? 5'b10100 : i == 2 ? 5'b11110 :
                i == 3 ? 5'b10000 : 5'b01011;
            acc = !rc[0] && (!rc[2] || rc[1]);
            d = $urandom;
            wr(ADDR_CTRL, {rc[4:2], 4'h8, rc[0]});
            peer.sendFrame({1'b1, rc[1], d, 1'b0}, i == 0);
            repeat (32) @(posedge clk_sys);
            rd(ADDR_CTRL, 1'b1, {rc[4:2], 2'h2, acc & rc[1], 1'b0, acc | rc[0]});
            if (acc) lastBuf = d;
            rd(ADDR_BUF, 1'b1, lastBuf);
        end
        $display("async receive test done");
        final_report();
    end
endmodule : tb_top
bind serial_port_four_mode serial_port_four_mode_asserts u_chk (.clk_sys,
    .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .portThreeBitZeroOeN, .portThreeBitOneOut);
